// ==== inc/smh_params.svh ====
// Constants for the servo mode select and homing block
`ifndef SMH_PARAMS_SVH
`define SMH_PARAMS_SVH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define SMH_DW 32
`define SMH_SETW 4
`define SMH_METHW 8

// ----------------------------------------------------------------
// Operating-mode setting codes
// ----------------------------------------------------------------
`define SMH_SET_INDEX 4'h0
`define SMH_SET_PULSE 4'h1
`define SMH_SET_VEL 4'h2
`define SMH_SET_TORQUE 4'h3
`define SMH_SET_PULSE_INDEX 4'h4
`define SMH_SET_PULSE_VEL 4'h5
`define SMH_SET_PULSE_TORQUE 4'h6
`define SMH_SET_VEL_TORQUE 4'h7
`define SMH_SET_INDEX_VEL 4'h8
`define SMH_SET_INDEX_TORQUE 4'h9

// ----------------------------------------------------------------
// Homing method codes (signed byte)
// ----------------------------------------------------------------
`define SMH_HM_NEG_LIMIT 8'h01
`define SMH_HM_POS_LIMIT 8'h02
`define SMH_HM_FWD_FIRST 8'h07
`define SMH_HM_FWD_LAST 8'h0A
`define SMH_HM_REV_FIRST 8'h0B
`define SMH_HM_REV_LAST 8'h0E
`define SMH_HM_FWD_HOME_ONLY 8'h18
`define SMH_HM_HERE 8'h23

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SMH_CLK_HZ 200000000
`define SMH_RAMP_TICK_US 1000
`define SMH_US_PER_S 1000000
`define SMH_RAMP_CYCLES (`SMH_CLK_HZ / `SMH_US_PER_S * `SMH_RAMP_TICK_US)
`define SMH_TICKS_PER_S (`SMH_US_PER_S / `SMH_RAMP_TICK_US)

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SMH_RST_WORD 32'h0000_0000

`endif

// ==== inc/smh_pkg.sv ====
// Types for the servo mode select and homing block
`include "smh_params.svh"

package smh_pkg;

	typedef enum logic [3:0] {
		SMH_OP_INDEX = 4'b0001,
		SMH_OP_PULSE = 4'b0010,
		SMH_OP_VEL = 4'b0100,
		SMH_OP_TORQUE = 4'b1000
	} smh_op_e;

	typedef enum logic [2:0] {
		SMH_HS_IDLE = 3'b001,
		SMH_HS_SEARCH = 3'b010,
		SMH_HS_CREEP = 3'b100
	} smh_hst_e;

	typedef struct packed {
		logic supported;
		logic no_motion;
		logic start_fwd;
		logic rev_on_limit;
		logic trig_limit;
		logic need_index;
	} smh_hcfg_s;

	typedef struct packed {
		smh_op_e op_mode;
		logic mode_err;
		smh_hst_e hst;
		smh_hcfg_s cfg;
		logic dir_fwd;
		logic [`SMH_DW-1:0] speed;
		logic [`SMH_DW-1:0] target;
		logic [`SMH_DW-1:0] step;
		logic [`SMH_DW-1:0] zero_speed;
		logic [`SMH_DW-1:0] tick_cnt;
		logic busy;
		logic done;
		logic err;
		logic preset_vld;
		logic [`SMH_DW-1:0] preset_val;
		logic start_d;
		logic idx_d;
		logic plim_d;
		logic nlim_d;
		logic zero_spd;
	} smh_state_s;

endpackage

// ==== rtl/smh_sync.sv ====
// Two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/1ps

module smh_sync #(
	parameter int WIDTH = 1
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] sync_out
);

	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} smh_sync_s;

	smh_sync_s s_r;
	smh_sync_s s_nxt;

	// First stage feeds only the second stage
	always_comb begin
		s_nxt = s_r;
		s_nxt.meta = pin_in;
		s_nxt.stable = s_r.meta;
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign sync_out = s_r.stable;

endmodule

// ==== rtl/smh_top.sv ====
// Operating-mode selection and homing sequencer of the servo drive
//
// How it works
// RULE1: Settings 0..3 select indexing, pulse, velocity or torque as a fixed mode.
// RULE2: Setting 4: pulse position with mode input off, indexing position with it on.
// RULE3: Setting 5: pulse position by default, velocity when mode input asserted.
// RULE4: Setting 6: pulse position basic, torque while mode input on.
// RULE5: Setting 7: velocity basic, torque while mode input on.
// RULE6: Setting 8: indexing position by default, velocity when mode input asserted.
// RULE7: Setting 9: indexing position basic, torque while mode input on.
// RULE8: After reset a dual setting starts basic, alternate only on mode input.
// RULE9: A home offset places machine zero where the actual position reads zero.
// RULE10: Homing starts only on start input while zero-speed output is high.
// RULE11: Homing velocities, acceleration, offset and method are used in the sequence.
// RULE12: The stored homing-method code picks the homing behaviour.
// RULE13: Method 1: reverse, negative limit then index pulse.
// RULE14: Method 2: forward, positive limit then index pulse.
// RULE15: Methods 7..10: forward, home switch and index; positive limit reverses.
// RULE16: Methods 11..14: reverse, home switch and index; negative limit reverses.
// RULE17: Method 24: forward, home switch alone; positive limit reverses.
// RULE18: Method 1 turns forward at zero-search speed on the limit, stops at index.
// RULE19: Method 35 takes the present position as home without motion.
// RULE20: Settings 0..3 ignore the mode input.
`timescale 1ns/1ps
`include "smh_params.svh"

module smh_top
	import smh_pkg::*;
#(
	parameter int RAMP_CYCLES = `SMH_RAMP_CYCLES
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic [`SMH_SETW-1:0] operating_mode_setting,
	input wire logic mode_input,
	input wire logic homing_start_input,
	input wire logic positive_limit_input,
	input wire logic negative_limit_input,
	input wire logic home_switch_input,
	input wire logic index_pulse_input,
	input wire logic motor_at_rest,
	input wire logic [`SMH_METHW-1:0] homing_method,
	input wire logic [`SMH_DW-1:0] switch_search_speed,
	input wire logic [`SMH_DW-1:0] zero_search_speed,
	input wire logic [`SMH_DW-1:0] homing_accel,
	input wire logic [`SMH_DW-1:0] home_offset,
	output logic [3:0] op_mode,
	output logic mode_setting_error,
	output logic zero_speed_output,
	output logic homing_busy,
	output logic homing_done,
	output logic homing_error,
	output logic homing_dir_fwd,
	output logic [`SMH_DW-1:0] homing_speed_cmd,
	output logic position_preset_valid,
	output logic [`SMH_DW-1:0] position_preset_value
);

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [5:0] pins_s;
	logic mode_s;
	logic start_s;
	logic plim_s;
	logic nlim_s;
	logic home_s;
	logic idx_s;

	smh_sync #(
		.WIDTH(6)
	) u_sync (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.pin_in({mode_input, homing_start_input, positive_limit_input,
			negative_limit_input, home_switch_input, index_pulse_input}),
		.sync_out(pins_s)
	);

	assign {mode_s, start_s, plim_s, nlim_s, home_s, idx_s} = pins_s;

	// ----------------------------------------------------------------
	// Decoders
	// ----------------------------------------------------------------
	// Returns {valid, mode}; unknown settings report invalid
	function automatic logic [4:0] pick_mode(input logic [`SMH_SETW-1:0] set, input logic alt);
		smh_op_e m;
		logic ok;
		m = SMH_OP_PULSE;
		ok = 1'b1;
		case (set)
			`SMH_SET_INDEX: m = SMH_OP_INDEX; // RULE1 RULE20
			`SMH_SET_PULSE: m = SMH_OP_PULSE; // RULE1 RULE20
			`SMH_SET_VEL: m = SMH_OP_VEL; // RULE1 RULE20
			`SMH_SET_TORQUE: m = SMH_OP_TORQUE; // RULE1 RULE20
			`SMH_SET_PULSE_INDEX: m = alt ? SMH_OP_INDEX : SMH_OP_PULSE; // RULE2
			`SMH_SET_PULSE_VEL: m = alt ? SMH_OP_VEL : SMH_OP_PULSE; // RULE3
			`SMH_SET_PULSE_TORQUE: m = alt ? SMH_OP_TORQUE : SMH_OP_PULSE; // RULE4
			`SMH_SET_VEL_TORQUE: m = alt ? SMH_OP_TORQUE : SMH_OP_VEL; // RULE5
			`SMH_SET_INDEX_VEL: m = alt ? SMH_OP_VEL : SMH_OP_INDEX; // RULE6
			`SMH_SET_INDEX_TORQUE: m = alt ? SMH_OP_TORQUE : SMH_OP_INDEX; // RULE7
			default: ok = 1'b0;
		endcase
		return {ok, m};
	endfunction

	function automatic smh_hcfg_s decode_method(input logic [`SMH_METHW-1:0] hm);
		smh_hcfg_s c;
		c = '0;
		c.supported = 1'b1;
		if (hm == `SMH_HM_NEG_LIMIT) begin
			c.trig_limit = 1'b1; // RULE13
			c.need_index = 1'b1;
		end else if (hm == `SMH_HM_POS_LIMIT) begin
			c.start_fwd = 1'b1; // RULE14
			c.trig_limit = 1'b1;
			c.need_index = 1'b1;
		end else if (hm >= `SMH_HM_FWD_FIRST && hm <= `SMH_HM_FWD_LAST) begin
			c.start_fwd = 1'b1; // RULE15
			c.rev_on_limit = 1'b1;
			c.need_index = 1'b1;
		end else if (hm >= `SMH_HM_REV_FIRST && hm <= `SMH_HM_REV_LAST) begin
			c.rev_on_limit = 1'b1; // RULE16
			c.need_index = 1'b1;
		end else if (hm == `SMH_HM_FWD_HOME_ONLY) begin
			c.start_fwd = 1'b1; // RULE17
			c.rev_on_limit = 1'b1;
		end else if (hm == `SMH_HM_HERE) begin
			c.no_motion = 1'b1; // RULE19
		end else begin
			c.supported = 1'b0;
		end
		return c;
	endfunction

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	smh_state_s s_r;
	smh_state_s s_nxt;
	logic [4:0] mode_pick;
	logic start_rise;
	logic idx_rise;
	logic travel_lim;
	logic travel_lim_rise;
	logic ramp_tick;

	assign mode_pick = pick_mode(operating_mode_setting, mode_s);
	assign start_rise = start_s & ~s_r.start_d;
	assign idx_rise = idx_s & ~s_r.idx_d;
	assign travel_lim = s_r.dir_fwd ? plim_s : nlim_s;
	assign travel_lim_rise = s_r.dir_fwd ? (plim_s & ~s_r.plim_d) : (nlim_s & ~s_r.nlim_d);
	assign ramp_tick = (s_r.tick_cnt == `SMH_DW'(RAMP_CYCLES - 1));

	always_comb begin
		s_nxt = s_r;
		s_nxt.done = 1'b0;
		s_nxt.preset_vld = 1'b0;
		s_nxt.start_d = start_s;
		s_nxt.idx_d = idx_s;
		s_nxt.plim_d = plim_s;
		s_nxt.nlim_d = nlim_s;
		s_nxt.zero_spd = motor_at_rest;
		s_nxt.tick_cnt = ramp_tick ? '0 : s_r.tick_cnt + 1'b1;

		// Unknown setting keeps the last good mode rather than jumping
		s_nxt.mode_err = ~mode_pick[4];
		if (mode_pick[4]) begin
			s_nxt.op_mode = smh_op_e'(mode_pick[3:0]); // RULE8
		end

		// Speed ramp toward target, one step per tick
		if (ramp_tick) begin // RULE11
			if (s_r.speed < s_r.target) begin
				s_nxt.speed = (s_r.target - s_r.speed > s_r.step) ?
					s_r.speed + s_r.step : s_r.target;
			end else if (s_r.speed > s_r.target) begin
				s_nxt.speed = (s_r.speed - s_r.target > s_r.step) ?
					s_r.speed - s_r.step : s_r.target;
			end
		end

		unique case (s_r.hst)
			SMH_HS_IDLE: begin
				s_nxt.speed = '0;
				s_nxt.target = '0;
				s_nxt.busy = 1'b0;
				if (start_rise && s_r.zero_spd) begin // RULE10
					s_nxt.cfg = decode_method(homing_method); // RULE12
					s_nxt.err = 1'b0;
					s_nxt.preset_val = home_offset; // RULE9
					if (!s_nxt.cfg.supported) begin
						s_nxt.err = 1'b1;
					end else if (s_nxt.cfg.no_motion) begin
						s_nxt.preset_vld = 1'b1; // RULE19
						s_nxt.done = 1'b1;
					end else begin
						s_nxt.busy = 1'b1;
						s_nxt.dir_fwd = s_nxt.cfg.start_fwd;
						s_nxt.target = switch_search_speed; // RULE11 RULE18
						s_nxt.zero_speed = zero_search_speed;
						s_nxt.step = `SMH_DW'(homing_accel / `SMH_TICKS_PER_S);
						s_nxt.hst = SMH_HS_SEARCH;
					end
				end
			end
			SMH_HS_SEARCH: begin
				if (s_r.cfg.trig_limit) begin
					if (travel_lim) begin
						s_nxt.dir_fwd = ~s_r.dir_fwd; // RULE13 RULE14 RULE18
						s_nxt.target = s_r.zero_speed;
						s_nxt.hst = SMH_HS_CREEP;
					end
				end else if (home_s) begin
					if (s_r.cfg.need_index) begin
						s_nxt.target = s_r.zero_speed; // RULE15 RULE16
						s_nxt.hst = SMH_HS_CREEP;
					end else begin
						s_nxt.preset_vld = 1'b1; // RULE17
						s_nxt.done = 1'b1;
						s_nxt.busy = 1'b0;
						s_nxt.hst = SMH_HS_IDLE;
					end
				end else if (s_r.cfg.rev_on_limit && travel_lim_rise) begin
					s_nxt.dir_fwd = ~s_r.dir_fwd; // RULE15 RULE16 RULE17
				end
			end
			SMH_HS_CREEP: begin
				if (idx_rise) begin
					s_nxt.preset_vld = 1'b1; // RULE18
					s_nxt.done = 1'b1;
					s_nxt.busy = 1'b0;
					s_nxt.hst = SMH_HS_IDLE;
				end
			end
			default: begin
				s_nxt.hst = SMH_HS_IDLE;
				s_nxt.busy = 1'b0;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			s_r <= '0;
			s_r.op_mode <= SMH_OP_PULSE;
			s_r.hst <= SMH_HS_IDLE;
			s_r.dir_fwd <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign op_mode = s_r.op_mode;
	assign mode_setting_error = s_r.mode_err;
	assign zero_speed_output = s_r.zero_spd;
	assign homing_busy = s_r.busy;
	assign homing_done = s_r.done;
	assign homing_error = s_r.err;
	assign homing_dir_fwd = s_r.dir_fwd;
	assign homing_speed_cmd = s_r.speed;
	assign position_preset_valid = s_r.preset_vld;
	assign position_preset_value = s_r.preset_val;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	chk_fixed_torque: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE1
		operating_mode_setting == `SMH_SET_TORQUE |=> op_mode == SMH_OP_TORQUE)
		else $error("Fixed torque setting did not give torque mode");
	chk_fixed_ignores_in: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE20
		operating_mode_setting == `SMH_SET_INDEX && $changed(mode_s) |=> op_mode == SMH_OP_INDEX)
		else $error("Mode input changed a fixed mode");
	chk_pulse_index_pair: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE2
		operating_mode_setting == `SMH_SET_PULSE_INDEX |=>
		op_mode == ($past(mode_s) ? SMH_OP_INDEX : SMH_OP_PULSE))
		else $error("Setting 4 mode wrong");
	chk_vel_torque_pair: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE5
		operating_mode_setting == `SMH_SET_VEL_TORQUE && !mode_s |=> op_mode == SMH_OP_VEL)
		else $error("Setting 7 left velocity without mode input");
	chk_index_torque_alt: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE7
		operating_mode_setting == `SMH_SET_INDEX_TORQUE && mode_s |=> op_mode == SMH_OP_TORQUE)
		else $error("Setting 9 alternate not torque");
	chk_start_gate: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE10
		$rose(homing_busy) |-> $past(zero_speed_output) && $past(start_s))
		else $error("Homing began without start and zero speed");
	chk_here_no_motion: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE19
		s_r.hst == SMH_HS_IDLE && start_rise && s_r.zero_spd && homing_method == `SMH_HM_HERE
		|=> position_preset_valid && !homing_busy && homing_speed_cmd == '0)
		else $error("Method 35 did not preset at once");
	chk_limit_turns: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE18
		s_r.hst == SMH_HS_SEARCH && s_r.cfg.trig_limit && travel_lim
		|=> homing_dir_fwd != $past(homing_dir_fwd) && s_r.hst == SMH_HS_CREEP)
		else $error("Limit did not turn the search");
	chk_index_stops: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE13
		s_r.hst == SMH_HS_CREEP && idx_rise
		|=> homing_done && position_preset_valid ##1 !homing_done && !homing_busy)
		else $error("Index pulse did not finish homing");
	chk_preset_offset: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE9
		s_r.hst == SMH_HS_IDLE && start_rise && s_r.zero_spd
		|=> position_preset_value == $past(home_offset))
		else $error("Preset value lost the home offset");

	cov_dual_switch: cover property (@(posedge sys_clk) disable iff (sys_rst)
		operating_mode_setting == `SMH_SET_PULSE_VEL && $rose(mode_s) ##1 op_mode == SMH_OP_VEL);
	cov_home_limit: cover property (@(posedge sys_clk) disable iff (sys_rst)
		s_r.hst == SMH_HS_CREEP ##[1:1000] homing_done);
	cov_home_reverse: cover property (@(posedge sys_clk) disable iff (sys_rst)
		s_r.hst == SMH_HS_SEARCH && s_r.cfg.rev_on_limit && travel_lim_rise);
	cov_bad_method: cover property (@(posedge sys_clk) disable iff (sys_rst) $rose(homing_error));

endmodule

// ==== sim/smh_far_model.sv ====
// Behavioural axis with limit, home and index switches driven by homing motion
`timescale 1ns/1ps

module smh_far_model #(
	parameter int STEP_CYCLES = 8,
	parameter int NEG_LIM = -20,
	parameter int POS_LIM = 20,
	parameter int HOME_LO = 8,
	parameter int HOME_HI = 12
) (
	input wire logic sys_clk,
	input wire logic homing_busy,
	input wire logic homing_dir_fwd,
	input wire logic load_en,
	input wire logic [31:0] load_pos,
	output logic positive_limit_input,
	output logic negative_limit_input,
	output logic home_switch_input,
	output logic index_pulse_input
);
	int pos_r = 0;
	int cnt_r = 0;
	int pos_nxt;

	// ----------------------------------------------------------------
	// Motion: one position step per STEP_CYCLES while homing moves
	// ----------------------------------------------------------------
	always @(posedge sys_clk) begin
		pos_nxt = pos_r;
		if (load_en === 1'b1) begin
			pos_nxt = int'($signed(load_pos));
			cnt_r <= 0;
		end else if (homing_busy === 1'b1) begin
			if (cnt_r == STEP_CYCLES - 1) begin
				cnt_r <= 0;
				pos_nxt = pos_r + ((homing_dir_fwd === 1'b1) ? 1 : -1);
			end else begin
				cnt_r <= cnt_r + 1;
			end
		end
		// Index mark away from switch edges, so no two events coincide
		index_pulse_input <= (pos_nxt != pos_r) && ((((pos_nxt % 8) + 8) % 8) == 6);
		pos_r <= pos_nxt;
		positive_limit_input <= (pos_nxt >= POS_LIM);
		negative_limit_input <= (pos_nxt <= NEG_LIM);
		home_switch_input <= (pos_nxt >= HOME_LO) && (pos_nxt <= HOME_HI);
	end
endmodule

// ==== sim/tb.sv ====
// Self-checking bench for mode selection and homing
`timescale 1ns/1ps
`include "smh_params.svh"

module tb
	import smh_pkg::*;
;
	typedef struct {
		logic [31:0] val;
		logic dir;
		bit dcare;
	} smh_tb_exp_s;

	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [`SMH_SETW-1:0] operating_mode_setting = 4'h7;
	logic mode_input = 1'b0;
	logic homing_start_input = 1'b0;
	logic positive_limit_input;
	logic negative_limit_input;
	logic home_switch_input;
	logic index_pulse_input;
	logic motor_at_rest = 1'b1;
	logic [`SMH_METHW-1:0] homing_method = 8'h01;
	logic [`SMH_DW-1:0] switch_search_speed = 32'h0000_0064;
	logic [`SMH_DW-1:0] zero_search_speed = 32'h0000_000A;
	logic [`SMH_DW-1:0] homing_accel = 32'h0000_03E8;
	logic [`SMH_DW-1:0] home_offset = 32'h0000_0000;
	logic [3:0] op_mode;
	logic mode_setting_error;
	logic zero_speed_output;
	logic homing_busy;
	logic homing_done;
	logic homing_error;
	logic homing_dir_fwd;
	logic [`SMH_DW-1:0] homing_speed_cmd;
	logic position_preset_valid;
	logic [`SMH_DW-1:0] position_preset_value;
	logic model_load_en = 1'b0;
	logic [31:0] model_load_pos = 32'h0000_0000;
	int mismatches = 0;
	int n_checks = 0;
	int n_done = 0;
	int seed_v;
	smh_tb_exp_s exp_q [$];
	smh_op_e mode_basic [10] = '{SMH_OP_INDEX, SMH_OP_PULSE, SMH_OP_VEL, SMH_OP_TORQUE,
		SMH_OP_PULSE, SMH_OP_PULSE, SMH_OP_PULSE, SMH_OP_VEL, SMH_OP_INDEX, SMH_OP_INDEX};
	smh_op_e mode_alt [10] = '{SMH_OP_INDEX, SMH_OP_PULSE, SMH_OP_VEL, SMH_OP_TORQUE,
		SMH_OP_INDEX, SMH_OP_VEL, SMH_OP_TORQUE, SMH_OP_TORQUE, SMH_OP_VEL, SMH_OP_TORQUE};

	smh_top #(.RAMP_CYCLES(8)) u_smh_top (
		.sys_clk(sys_clk), .sys_rst(sys_rst),
		.operating_mode_setting(operating_mode_setting), .mode_input(mode_input),
		.homing_start_input(homing_start_input),
		.positive_limit_input(positive_limit_input), .negative_limit_input(negative_limit_input),
		.home_switch_input(home_switch_input), .index_pulse_input(index_pulse_input),
		.motor_at_rest(motor_at_rest), .homing_method(homing_method),
		.switch_search_speed(switch_search_speed), .zero_search_speed(zero_search_speed),
		.homing_accel(homing_accel), .home_offset(home_offset),
		.op_mode(op_mode), .mode_setting_error(mode_setting_error),
		.zero_speed_output(zero_speed_output), .homing_busy(homing_busy),
		.homing_done(homing_done), .homing_error(homing_error),
		.homing_dir_fwd(homing_dir_fwd), .homing_speed_cmd(homing_speed_cmd),
		.position_preset_valid(position_preset_valid),
		.position_preset_value(position_preset_value)
	);

	smh_far_model u_smh_far_model (
		.sys_clk(sys_clk), .homing_busy(homing_busy), .homing_dir_fwd(homing_dir_fwd),
		.load_en(model_load_en), .load_pos(model_load_pos),
		.positive_limit_input(positive_limit_input), .negative_limit_input(negative_limit_input),
		.home_switch_input(home_switch_input), .index_pulse_input(index_pulse_input)
	);

	initial begin
		forever #2.5 sys_clk = ~sys_clk;
	end

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic conclude;
		$display("checks=%0d mismatches=%0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// One homing run from a chosen axis position; d0 start direction, d1 final one
	task automatic run_home(input logic [7:0] meth, input int p0, input logic d0,
		input logic d1, input bit moves);
		smh_tb_exp_s e;
		int k;
		int nd;
		logic [31:0] smax;
		logic [31:0] s1;
		homing_method = meth;
		switch_search_speed = 32'($urandom_range(900, 100));
		zero_search_speed = 32'($urandom_range(90, 10));
		homing_accel = 32'($urandom_range(99000, 1000));
		home_offset = $urandom;
		model_load_en = 1'b1;
		model_load_pos = 32'(p0);
		tick(1);
		model_load_en = 1'b0;
		e.val = home_offset;
		e.dir = d1;
		e.dcare = moves;
		exp_q.push_back(e);
		nd = n_done;
		smax = 32'h0000_0000;
		s1 = 32'h0000_0000;
		k = 0;
		while (zero_speed_output !== 1'b1 && k < 50) begin
			tick(1);
			k++;
		end
		homing_start_input = 1'b1;
		tick(4);
		homing_start_input = 1'b0;
		if (moves) chk(32'(homing_dir_fwd), 32'(d0));
		k = 0;
		while (n_done == nd && k < 3000) begin
			if (homing_busy === 1'b1 && homing_speed_cmd > smax) smax = homing_speed_cmd;
			if (homing_busy === 1'b1 && s1 == 0) s1 = homing_speed_cmd;
			tick(1);
			k++;
		end
		chk(32'(n_done - nd), 32'h0000_0001);
		if (moves) chk(32'(smax != 0 && smax <= switch_search_speed), 32'h0000_0001);
		if (moves) chk(s1, homing_accel / `SMH_TICKS_PER_S);
	endtask

	// ----------------------------------------------------------------
	// Result watcher: each completion takes the oldest expectation
	// ----------------------------------------------------------------
	always @(posedge sys_clk) begin
		smh_tb_exp_s e;
		if (homing_done === 1'b1) begin
			n_done++;
			if (exp_q.size() == 0) begin
				chk(32'h0000_0000, 32'h0000_0001);
			end else begin
				e = exp_q.pop_front();
				chk(32'(position_preset_valid), 32'h0000_0001);
				chk(position_preset_value, e.val);
				chk(32'(homing_busy), 32'h0000_0000);
				if (e.dcare) chk(32'(homing_dir_fwd), 32'(e.dir));
			end
		end
	end

	initial begin
		repeat (30000) @(posedge sys_clk);
		mismatches++;
		conclude();
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		seed_v = $urandom(2);
		tick(4);
		sys_rst = 1'b0;
		tick(5);
		chk(32'(op_mode), 32'(SMH_OP_VEL));
		mode_input = 1'b1;
		tick(5);
		chk(32'(op_mode), 32'(SMH_OP_TORQUE));
		for (int s = 0; s < 10; s++) begin
			for (int m = 0; m < 2; m++) begin
				operating_mode_setting = 4'(s);
				mode_input = m[0];
				tick(5);
				chk(32'(op_mode), 32'(m ? mode_alt[s] : mode_basic[s]));
			end
		end
		// Out-of-range setting keeps the last mode
		operating_mode_setting = 4'hC;
		tick(3);
		chk(32'(mode_setting_error), 32'h0000_0001);
		chk(32'(op_mode), 32'(SMH_OP_TORQUE));
		operating_mode_setting = 4'h1;
		mode_input = 1'b0;
		tick(5);
		chk(32'(mode_setting_error), 32'h0000_0000);
		// Start while the motor is still turning must be ignored
		motor_at_rest = 1'b0;
		tick(3);
		chk(32'(zero_speed_output), 32'h0000_0000);
		homing_start_input = 1'b1;
		tick(4);
		homing_start_input = 1'b0;
		tick(4);
		chk(32'(homing_busy), 32'h0000_0000);
		chk(32'(n_done), 32'h0000_0000);
		motor_at_rest = 1'b1;
		tick(3);
		chk(32'(zero_speed_output), 32'h0000_0001);
		run_home(8'h01, 0, 1'b0, 1'b1, 1'b1);
		run_home(8'h02, 0, 1'b1, 1'b0, 1'b1);
		for (int i = 7; i <= 10; i++) run_home(8'(i), 13, 1'b1, 1'b0, 1'b1);
		for (int i = 11; i <= 14; i++) run_home(8'(i), 4, 1'b0, 1'b1, 1'b1);
		run_home(8'h18, 0, 1'b1, 1'b1, 1'b1);
		homing_method = 8'h03;
		homing_start_input = 1'b1;
		tick(4);
		homing_start_input = 1'b0;
		chk(32'(homing_error), 32'h0000_0001);
		chk(32'(homing_busy), 32'h0000_0000);
		tick(2);
		run_home(8'h23, 0, 1'b0, 1'b0, 1'b0);
		chk(32'(homing_error), 32'h0000_0000);
		conclude();
	end
endmodule
